// file: common/slow_clock_pkg.sv
package slow_clock_pkg;
  // register offsets (printed offsets are not all multiples of four: index, byte address = 4 * index)
  localparam logic [7:0] IDX_OSC_CONTROL_0 = 8'hE0;
  localparam logic [7:0] IDX_SLOW_OSC_TRIM = 8'hE9;
  localparam logic [7:0] IDX_CRYSTAL_OSC_TRIM = 8'hEB;
  localparam logic [7:0] IDX_SLOW_STATUS = 8'hF0;
  localparam logic [9:0] ADDR_OSC_CONTROL_0 = {IDX_OSC_CONTROL_0, 2'b00};
  localparam logic [9:0] ADDR_SLOW_OSC_TRIM = {IDX_SLOW_OSC_TRIM, 2'b00};
  localparam logic [9:0] ADDR_CRYSTAL_OSC_TRIM = {IDX_CRYSTAL_OSC_TRIM, 2'b00};
  localparam logic [9:0] ADDR_SLOW_STATUS = {IDX_SLOW_STATUS, 2'b00};
  // osc_control_0 fields
  localparam int SLOW_SOURCE_SELECT_BIT = 7;
  localparam int PLL_MODE_BIT = 6;
  localparam int SLEEP_LSB = 3;
  localparam int CPU_LSB = 0;
  localparam logic [7:0] OSC_CONTROL_0_RESET = 8'h00;
  localparam logic [7:0] OSC_CONTROL_0_WMASK = 8'hDF;
  // trim register layouts
  localparam logic [7:0] SLOW_TRIM_WMASK = 8'h7F;
  localparam logic [7:0] CRYSTAL_TRIM_WMASK = 8'hCF;
  localparam logic [7:0] SLOW_TRIM_FACTORY = 8'h20;
  localparam logic [7:0] CRYSTAL_TRIM_FACTORY = 8'h05;
  // status bits
  localparam int STAT_CRYSTAL_ACTIVE_BIT = 0;
  localparam int STAT_SWITCH_PENDING_BIT = 1;
  // pll figures
  localparam real PLL_REF_KHZ = 32.768;
  localparam real PLL_OUT_MHZ = 23.986;
  localparam int PLL_MULTIPLIER = 732;
  // switch states
  typedef enum logic [2:0] {
    SW_SLOW_OSC = 3'b001,
    SW_PENDING = 3'b010,
    SW_CRYSTAL = 3'b100
  } switch_state_t;
endpackage

// file: common/switch_if.sv
interface switch_if;
  logic selectReq;
  logic terminalCount;
  logic crystalActive;
  logic pending;
  modport ctrl (output selectReq, output terminalCount, input crystalActive, input pending);
  modport mux (input selectReq, input terminalCount, output crystalActive, output pending);
endinterface

// file: rtl/slow_clock_source_switch.sv
// Notes on behaviour
// - after reset the slow clock bus comes from the slow internal oscillator
// - bit 7 of osc_control_0 requests the crystal; cleared at reset
// - slow internal oscillator keeps running and sourcing until switchover
// - switchover happens at sleep timer terminal count, interrupt enable irrelevant
// - crystal trim loads a factory value at reset and never alters frequency
// - pll from a 32.768 kHz crystal gives 23.986 MHz system clock
// - pll enabled only once crystal is the active source
module slow_clock_source_switch
  import slow_clock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [9:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleepTerminalCount,
  output logic crystalSelected,
  output logic slowOscEnable,
  output logic pllEnable,
  output logic [1:0] sleepPeriod,
  output logic [2:0] cpuSpeed,
  output logic [5:0] slowOscTrimValue,
  output logic [7:0] crystalTrimValue
);
  logic [7:0] oscControl0_reg, oscControl0_next;
  logic [7:0] slowOscTrim_reg, slowOscTrim_next;
  logic [7:0] crystalOscTrim_reg, crystalOscTrim_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic crystalSel_reg, crystalSel_next;
  logic pllEn_reg, pllEn_next;
  logic slowOscEn_reg, slowOscEn_next;
  logic access;
  switch_if sw ();

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] mask);
    merge = (old & ~mask) | (wd & mask);
  endfunction

  function automatic logic known_addr(input logic [9:0] a);
    known_addr = (a == ADDR_OSC_CONTROL_0) || (a == ADDR_SLOW_OSC_TRIM) ||
      (a == ADDR_CRYSTAL_OSC_TRIM) || (a == ADDR_SLOW_STATUS);
  endfunction

  // one wait state: answer in the cycle after the first access cycle
  assign access = psel && penable && !pready_reg;

  // register file next values
  always_comb begin
    oscControl0_next = oscControl0_reg;
    slowOscTrim_next = slowOscTrim_reg;
    crystalOscTrim_next = crystalOscTrim_reg;
    prdata_next = 32'h0000_0000;
    pready_next = access;
    pslverr_next = access && !known_addr(paddr);
    if (access && pwrite) begin
      case (paddr)
        ADDR_OSC_CONTROL_0: oscControl0_next = merge(oscControl0_reg, pwdata[7:0], OSC_CONTROL_0_WMASK);
        ADDR_SLOW_OSC_TRIM: slowOscTrim_next = merge(slowOscTrim_reg, pwdata[7:0], SLOW_TRIM_WMASK);
        // trim only stored; it never feeds the crystal frequency path
        ADDR_CRYSTAL_OSC_TRIM: crystalOscTrim_next = merge(crystalOscTrim_reg, pwdata[7:0], CRYSTAL_TRIM_WMASK);
        default: ;
      endcase
    end
    if (access && !pwrite) begin
      case (paddr)
        ADDR_OSC_CONTROL_0: prdata_next = {24'h00_0000, oscControl0_reg[7], pllEn_reg, oscControl0_reg[5:0]};
        ADDR_SLOW_OSC_TRIM: prdata_next = {24'h00_0000, slowOscTrim_reg};
        ADDR_CRYSTAL_OSC_TRIM: prdata_next = {24'h00_0000, crystalOscTrim_reg};
        ADDR_SLOW_STATUS: prdata_next = {30'h0000_0000, sw.pending, sw.crystalActive};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      oscControl0_reg <= OSC_CONTROL_0_RESET;
      slowOscTrim_reg <= SLOW_TRIM_FACTORY;
      crystalOscTrim_reg <= CRYSTAL_TRIM_FACTORY;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      oscControl0_reg <= oscControl0_next;
      slowOscTrim_reg <= slowOscTrim_next;
      crystalOscTrim_reg <= crystalOscTrim_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // the switch sees the request and the timer wrap; interrupt enable plays no part
  assign sw.selectReq = oscControl0_reg[SLOW_SOURCE_SELECT_BIT];
  assign sw.terminalCount = sleepTerminalCount;

  slow_source_switch u_switch (
    .clk(clk),
    .reset(reset),
    .sw(sw)
  );

  // output flops: pll gated until crystal is active, so a premature enable waits
  always_comb begin
    crystalSel_next = sw.crystalActive;
    pllEn_next = oscControl0_reg[PLL_MODE_BIT] && sw.crystalActive;
    slowOscEn_next = !(crystalSel_next && slowOscTrim_next[6]); // registered so the pin never glitches
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      crystalSel_reg <= 1'b0;
      pllEn_reg <= 1'b0;
      slowOscEn_reg <= 1'b1;
    end else begin
      crystalSel_reg <= crystalSel_next;
      pllEn_reg <= pllEn_next;
      slowOscEn_reg <= slowOscEn_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign crystalSelected = crystalSel_reg;
  // slow oscillator stays on until crystal takes over, then honours its disable bit
  assign slowOscEnable = slowOscEn_reg;
  assign pllEnable = pllEn_reg;
  assign sleepPeriod = oscControl0_reg[SLEEP_LSB +: 2];
  assign cpuSpeed = oscControl0_reg[CPU_LSB +: 3];
  assign slowOscTrimValue = slowOscTrim_reg[5:0];
  assign crystalTrimValue = crystalOscTrim_reg;

  // reset leaves the slow oscillator in charge and the factory trims loaded
  a_reset_slow_src: assert property (@(posedge clk) disable iff (reset) $past(reset) |-> !crystalSelected)
    else $error("crystal selected right after reset");
  a_trim_reset_val: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> crystalTrimValue == CRYSTAL_TRIM_FACTORY)
    else $error("crystal trim not factory value");
  a_control_reset_val: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> oscControl0_reg == OSC_CONTROL_0_RESET)
    else $error("control register not cleared by reset");

  // the source only moves on a terminal count, in either direction
  a_sel_needs_tc: assert property (@(posedge clk) disable iff (reset)
    $rose(sw.crystalActive) |-> $past(sleepTerminalCount) && $past(sw.selectReq))
    else $error("switch without terminal count");
  a_back_needs_tc: assert property (@(posedge clk) disable iff (reset)
    $fell(sw.crystalActive) |-> $past(sleepTerminalCount) && !$past(sw.selectReq))
    else $error("switch back without terminal count");
  a_pending_from_req: assert property (@(posedge clk) disable iff (reset)
    (!sw.crystalActive && !sw.pending && sw.selectReq) |=> sw.pending)
    else $error("crystal request not taken");
  a_pending_holds: assert property (@(posedge clk) disable iff (reset)
    (sw.pending && sw.selectReq && !sleepTerminalCount) |=> !sw.crystalActive)
    else $error("switched while pending");
  a_status_exclusive: assert property (@(posedge clk) disable iff (reset)
    !(sw.pending && sw.crystalActive))
    else $error("pending and active together");
  a_sel_tracks_state: assert property (@(posedge clk) disable iff (reset)
    sw.crystalActive |=> crystalSelected)
    else $error("select output lags");

  // pll and slow oscillator enables follow the active source
  a_pll_after_xtal: assert property (@(posedge clk) disable iff (reset)
    pllEnable |-> crystalSelected)
    else $error("pll on before crystal active");
  a_pll_gated: assert property (@(posedge clk) disable iff (reset)
    !sw.crystalActive |=> !pllEnable)
    else $error("pll enabled without crystal source");
  a_pll_follows_mode: assert property (@(posedge clk) disable iff (reset)
    (sw.crystalActive && oscControl0_reg[PLL_MODE_BIT]) |=> pllEnable)
    else $error("pll mode not applied");
  a_slow_osc_runs: assert property (@(posedge clk) disable iff (reset)
    !crystalSelected |-> slowOscEnable)
    else $error("slow oscillator stopped early");
  a_slow_osc_off: assert property (@(posedge clk) disable iff (reset)
    (crystalSelected && slowOscTrim_reg[6]) |-> !slowOscEnable)
    else $error("slow oscillator disable ignored");

  // register bus writes and answer shape
  a_xtal_bit_write: assert property (@(posedge clk) disable iff (reset)
    (access && pwrite && paddr == ADDR_OSC_CONTROL_0) |=> oscControl0_reg[7] == $past(pwdata[7]))
    else $error("select bit not stored");
  a_trim_stays_put: assert property (@(posedge clk) disable iff (reset)
    !(access && pwrite && paddr == ADDR_CRYSTAL_OSC_TRIM) |=> $stable(crystalOscTrim_reg))
    else $error("crystal trim changed without a write");
  a_bad_write_ignored: assert property (@(posedge clk) disable iff (reset)
    (access && !known_addr(paddr)) |=> $stable(oscControl0_reg) && $stable(slowOscTrim_reg))
    else $error("unmapped access changed a register");
  a_apb_answer: assert property (@(posedge clk) disable iff (reset)
    (psel && penable && !pready) |=> pready)
    else $error("apb answer late");
  a_ready_one_cycle: assert property (@(posedge clk) disable iff (reset)
    pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (@(posedge clk) disable iff (reset)
    pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle_zero: assert property (@(posedge clk) disable iff (reset)
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer cycle");

  // main scenarios
  c_switch_done: cover property (@(posedge clk) $rose(crystalSelected));
  c_pll_on: cover property (@(posedge clk) $rose(pllEnable));
  c_back_to_slow: cover property (@(posedge clk) $fell(crystalSelected));
  c_bad_addr: cover property (@(posedge clk) pslverr);
  c_cancel: cover property (@(posedge clk) $fell(sw.pending) && !sw.crystalActive);
endmodule

// file: rtl/slow_source_switch.sv
module slow_source_switch
  import slow_clock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  switch_if.mux sw
);
  switch_state_t state_reg, state_next;

  // next state: selection only changes on a terminal count
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SW_SLOW_OSC: if (sw.selectReq) state_next = SW_PENDING;
      SW_PENDING: begin
        if (!sw.selectReq) state_next = SW_SLOW_OSC;
        else if (sw.terminalCount) state_next = SW_CRYSTAL;
      end
      SW_CRYSTAL: if (!sw.selectReq && sw.terminalCount) state_next = SW_SLOW_OSC;
      default: state_next = SW_SLOW_OSC;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) state_reg <= SW_SLOW_OSC;
    else state_reg <= state_next;
  end

  assign sw.crystalActive = (state_reg == SW_CRYSTAL);
  assign sw.pending = (state_reg == SW_PENDING);

  a_switch_waits_tc: assert property (@(posedge clk) disable iff (reset)
    (state_reg == SW_PENDING && !sw.terminalCount) |=> state_reg != SW_CRYSTAL)
    else $error("crystal selected without terminal count");
endmodule

// file: testbench/testbench.sv
module testbench
  import slow_clock_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleepTerminalCount = 1'b0;
  logic crystalSelected;
  logic slowOscEnable;
  logic pllEnable;
  logic [1:0] sleepPeriod;
  logic [2:0] cpuSpeed;
  logic [5:0] slowOscTrimValue;
  logic [7:0] crystalTrimValue;
  logic [31:0] rdData;
  logic errSeen;
  int miscompares = 0;
  int comparisons = 0;

  slow_clock_source_switch i_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepTerminalCount(sleepTerminalCount), .crystalSelected(crystalSelected), .slowOscEnable(slowOscEnable),
    .pllEnable(pllEnable), .sleepPeriod(sleepPeriod), .cpuSpeed(cpuSpeed), .slowOscTrimValue(slowOscTrimValue),
    .crystalTrimValue(crystalTrimValue));

  // 50 MHz system clock
  always #10 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] expected);
    comparisons++;
    if (seen !== expected) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, expected, seen);
    end
  endtask

  task automatic report_and_stop();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high at a rising edge, only the watchdog ends a wait
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one-cycle terminal count, then the fixed two-edge switch latency plus margin
  task automatic terminalCount();
    @(posedge clk);
    sleepTerminalCount <= 1'b1;
    @(posedge clk);
    sleepTerminalCount <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    check("crystalSelected", crystalSelected, 32'h0);
    check("slowOscEnable", slowOscEnable, 32'h1);
    check("slowOscTrimValue reset", slowOscTrimValue, {26'h0, SLOW_TRIM_FACTORY[5:0]});
    check("crystalTrimValue reset", crystalTrimValue, {24'h0, CRYSTAL_TRIM_FACTORY});
    apb(1'b0, ADDR_CRYSTAL_OSC_TRIM, 32'h0);
    check("crystal trim reset", rdData, {24'h0, CRYSTAL_TRIM_FACTORY});
    check("mapped error", errSeen, 32'h0);
    apb(1'b0, ADDR_SLOW_OSC_TRIM, 32'h0);
    check("slow trim reset", rdData, {24'h0, SLOW_TRIM_FACTORY});
    apb(1'b0, ADDR_OSC_CONTROL_0, 32'h0);
    check("control reset", rdData, {24'h0, OSC_CONTROL_0_RESET});
    // terminal count with nothing requested must not move the source
    terminalCount();
    check("crystalSelected idle tc", crystalSelected, 32'h0);
    // firmware order: 1 s sleep interval and a slow cpu first, crystal request after
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_001D);
    check("sleepPeriod", sleepPeriod, 32'h3);
    check("cpuSpeed", cpuSpeed, 32'h5);
    apb(1'b0, ADDR_SLOW_STATUS, 32'h0);
    check("status idle", rdData, 32'h0);
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_009D);
    apb(1'b0, ADDR_SLOW_STATUS, 32'h0);
    check("status pending", rdData, 32'h2);
    check("crystalSelected pending", crystalSelected, 32'h0);
    check("slowOscEnable pending", slowOscEnable, 32'h1);
    check("pllEnable pending", pllEnable, 32'h0);
    apb(1'b0, ADDR_OSC_CONTROL_0, 32'h0);
    check("control pending", rdData, 32'h9D);
    // disable bit set while the slow oscillator still sources the bus
    apb(1'b1, ADDR_SLOW_OSC_TRIM, 32'h0000_00E5);
    check("slowOscEnable disable pending", slowOscEnable, 32'h1);
    apb(1'b0, ADDR_SLOW_OSC_TRIM, 32'h0);
    check("slow trim write", rdData, 32'h0000_0065);
    check("slowOscTrimValue", slowOscTrimValue, 32'h25);
    terminalCount();
    check("crystalSelected switched", crystalSelected, 32'h1);
    check("slowOscEnable switched", slowOscEnable, 32'h0);
    check("pllEnable before mode", pllEnable, 32'h0);
    apb(1'b0, ADDR_SLOW_STATUS, 32'h0);
    check("status active", rdData, 32'h1);
    // pll mode only after the crystal has become the active source; reserved bit 5 not stored
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_00FD);
    @(negedge clk);
    check("pllEnable active", pllEnable, 32'h1);
    apb(1'b0, ADDR_OSC_CONTROL_0, 32'h0);
    check("control active", rdData, 32'hDD);
    // a second terminal count with the request still set changes nothing
    terminalCount();
    check("crystalSelected stays", crystalSelected, 32'h1);
    apb(1'b1, ADDR_CRYSTAL_OSC_TRIM, 32'h0000_00FF);
    apb(1'b0, ADDR_CRYSTAL_OSC_TRIM, 32'h0);
    check("crystal trim write", rdData, {24'h0, CRYSTAL_TRIM_WMASK});
    check("crystalTrimValue", crystalTrimValue, {24'h0, CRYSTAL_TRIM_WMASK});
    apb(1'b0, 10'h004, 32'h0);
    check("unmapped data", rdData, 32'h0);
    check("unmapped error", errSeen, 32'h1);
    // clear the request: switch back also waits for terminal count
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_0000);
    check("crystalSelected before tc", crystalSelected, 32'h1);
    terminalCount();
    check("crystalSelected back", crystalSelected, 32'h0);
    check("pllEnable back", pllEnable, 32'h0);
    check("slowOscEnable back", slowOscEnable, 32'h1);
    // a request cleared while pending is cancelled; pll mode alone stays held off
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_0080);
    apb(1'b0, ADDR_SLOW_STATUS, 32'h0);
    check("status pending again", rdData, 32'h2);
    apb(1'b1, ADDR_OSC_CONTROL_0, 32'h0000_0040);
    apb(1'b0, ADDR_SLOW_STATUS, 32'h0);
    check("status cancelled", rdData, 32'h0);
    terminalCount();
    check("crystalSelected cancelled", crystalSelected, 32'h0);
    check("pllEnable no crystal", pllEnable, 32'h0);
    report_and_stop();
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end
endmodule
